// [logic/pwr_mode_pkg.sv]
// Package with register map, field positions, reset values and mode types.
package pwr_mode_pkg;
   // Wake bytes keep their word index; the byte address is four times it.
   localparam logic [11:0] IDX_WAKE_LOW    = 12'hf4a;
   localparam logic [11:0] IDX_WAKE_HIGH   = 12'hf4b;
   localparam logic [13:0] ADDR_OSC_CTRL   = 14'h0f40;
   localparam logic [13:0] ADDR_WAKE_LOW   = {IDX_WAKE_LOW, 2'b00};
   localparam logic [13:0] ADDR_WAKE_HIGH  = {IDX_WAKE_HIGH, 2'b00};
   localparam logic [13:0] ADDR_WAKE_CFG   = 14'h0f50;
   localparam logic [13:0] ADDR_STATUS     = 14'h0f54;
   localparam int OSC_IDLE_BIT  = 7;
   localparam int OSC_STARTUP_TIMER_STATUS_BIT  = 3;
   localparam int CFG_DEEP_SLEEP_ARM_BIT  = 0;
   localparam int CFG_GIE_BIT   = 7;
   localparam int CFG_WDTEN_BIT = 1;
   localparam int CFG_FAIL_SAFE_CLOCK_MONITOR_BIT  = 2;
   localparam int WL_FLT   = 7;
   localparam int WL_ULP   = 5;
   localparam int WL_WDT   = 4;
   localparam int WL_RTC   = 3;
   localparam int WL_MASTER_CLEAR_PIN  = 2;
   localparam int WL_POR   = 0;
   localparam int WH_IOC   = 0;
   localparam logic [7:0] WAKE_LOW_MASK  = 8'h00_bd;
   localparam logic [7:0] WAKE_HIGH_MASK = 8'h00_01;
   localparam logic [7:0] WAKE_LOW_RESET = 8'h00_01;
   localparam logic [1:0] SCS_PRIMARY    = 2'h0;
   localparam logic [1:0] SCS_SECONDARY  = 2'h1;
   localparam logic [1:0] SCS_INTERNAL   = 2'h2;
   localparam logic [2:0] PRIMARY_OSC_CONFIG_EC        = 3'h4;
   localparam logic [2:0] PRIMARY_OSC_CONFIG_EXTERNAL_CLOCK_WITH_PLL     = 3'h5;
   localparam int OST_NS        = 51200;
   localparam int CLK_NS        = 50;
   localparam int OST_CYCLES    = (OST_NS + CLK_NS - 1) / CLK_NS;
   localparam int SWITCH_CYCLES = 4;
   typedef enum logic [2:0] {
      RUN, IDLE, SLEEP, DEEP_SLEEP, WAKE_WAIT
   } pm_state_t;
endpackage

// [logic/clock_switch_delay.sv]
// Cycle counter that models a clock transition or oscillator start-up wait.
`timescale 1ns/1ps
`default_nettype none
module clock_switch_delay #(
   parameter int WIDTH = 12
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] length,
   output logic                  busy
);
   logic [WIDTH-1:0] count;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (start) begin
         count <= length;
      end else if (count != '0) begin
         count <= count - WIDTH'(1);
      end
   end
   assign busy = (count != '0);
endmodule
`default_nettype wire

// [logic/power_mode_wake_control.sv]
// Power-managed mode controller with clock select and deep sleep wake cause.
`timescale 1ns/1ps
`default_nettype none
module power_mode_wake_control
   import pwr_mode_pkg::*;
#(
   parameter logic [2:0] PRIMARY_OSC_CONFIG = 3'h0,
   parameter bit         HAS_REGULATOR      = 1'b1,
   parameter int         OST_LEN            = OST_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [13:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sleep_op,
   input  wire logic        watchdog_clear_op,
   input  wire logic        int_flags_any_enabled,
   input  wire logic        watchdog_timeout,
   input  wire logic        clock_lost,
   input  wire logic [1:0]  source_running,
   input  wire logic        power_on_detect,
   input  wire logic        ds_fault,
   input  wire logic        ds_ultra_low_power_wake,
   input  wire logic        ds_watchdog,
   input  wire logic        ds_calendar_alarm,
   input  wire logic        ds_master_clear_pin,
   input  wire logic        ds_interrupt_on_change,
   output logic [1:0]       active_clock_source,
   output logic             cpu_clock_enable,
   output logic             periph_clock_enable,
   output logic             primary_osc_enable,
   output logic             internal_rc_clock_enable,
   output logic             core_supply_regulator_on,
   output logic             watchdog_clear,
   output logic             watchdog_reset_req,
   output logic             branch_to_vector,
   output logic             resume_pulse,
   output logic [2:0]       power_mode
);
   pm_state_t  state;
   pm_state_t  next_state;
   logic [1:0] clock_source_select;
   logic       idle_on_sleep_select;
   logic       deep_sleep_arm;
   logic       global_int_enable;
   logic       wdt_enable;
   logic       fail_safe_clock_monitor_enable;
   logic       startup_timer_status;
   logic [7:0] wake_low;
   logic [7:0] wake_high;
   logic       delay_busy;
   logic       delay_start;
   logic [11:0] delay_len;
   logic       int_prev;

   wire        wr_en     = psel && penable && pwrite;
   wire        sel_osc   = (paddr == ADDR_OSC_CTRL);
   wire        sel_wl    = (paddr == ADDR_WAKE_LOW);
   wire        sel_wh    = (paddr == ADDR_WAKE_HIGH);
   wire        sel_cfg   = (paddr == ADDR_WAKE_CFG);
   wire        sel_stat  = (paddr == ADDR_STATUS);
   wire        mapped    = sel_osc | sel_wl | sel_wh | sel_cfg | sel_stat;
   wire        wr_osc    = wr_en && sel_osc;
   wire [1:0]  new_scs   = pwdata[1:0];
   wire        low_power = (state == IDLE) || (state == SLEEP);
   // Exit begins on the rising edge of an enabled flag, not its level.
   wire        int_rise  = int_flags_any_enabled && !int_prev;
   wire        wake_evt  = low_power && (int_rise || watchdog_timeout);
   wire        ext_clk   = (PRIMARY_OSC_CONFIG == PRIMARY_OSC_CONFIG_EC) ||
                           (PRIMARY_OSC_CONFIG == PRIMARY_OSC_CONFIG_EXTERNAL_CLOCK_WITH_PLL);
   wire        src_ok    = source_running[new_scs[0]] || new_scs[1];
   wire        ds_in_any = ds_fault | ds_ultra_low_power_wake | ds_watchdog |
                           ds_calendar_alarm | ds_master_clear_pin |
                           ds_interrupt_on_change;
   wire        ds_seen   = (wake_low & 8'h00_bc) != 8'h00_00 || wake_high[0];

   clock_switch_delay #(.WIDTH(12)) u_delay (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (delay_start),
      .length  (delay_len),
      .busy    (delay_busy)
   );

   // Switch to primary or secondary needs that source running; internal is always taken; transition delay follows.
   assign delay_start = (wr_osc && src_ok && new_scs != clock_source_select) ||
                        (state == IDLE && wake_evt && !(ext_clk &&
                         clock_source_select == SCS_PRIMARY));
   assign delay_len   = wr_osc ? 12'(SWITCH_CYCLES) : 12'(OST_LEN);

   always_comb begin
      next_state = state;
      case (state)
         RUN: begin
            // Mode chosen from bits as they stood before the instruction.
            if (sleep_op) begin
               if (idle_on_sleep_select) begin
                  next_state = IDLE;
               end else if (deep_sleep_arm && HAS_REGULATOR) begin
                  next_state = DEEP_SLEEP;
               end else begin
                  next_state = SLEEP;
               end
            end
         end
         IDLE, SLEEP: begin
            if (wake_evt) begin
               next_state = WAKE_WAIT;
            end
         end
         DEEP_SLEEP: begin
            if (ds_in_any) begin
               next_state = WAKE_WAIT;
            end
         end
         WAKE_WAIT: begin
            if (!delay_busy) begin
               next_state = RUN;
            end
         end
         default: next_state = RUN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= RUN;
         int_prev <= 1'b0;
      end else begin
         state    <= next_state;
         int_prev <= int_flags_any_enabled;
      end
   end

   // Reset leaves the selection at internal RC; wake keeps bits as set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_source_select  <= SCS_INTERNAL;
         idle_on_sleep_select <= 1'b0;
         deep_sleep_arm       <= 1'b0;
         global_int_enable    <= 1'b0;
         wdt_enable           <= 1'b0;
         fail_safe_clock_monitor_enable          <= 1'b0;
      end else if (wr_osc) begin
         idle_on_sleep_select <= pwdata[OSC_IDLE_BIT];
         if (src_ok) begin
            clock_source_select <= new_scs;
         end
      end else if (wr_en && sel_cfg) begin
         deep_sleep_arm    <= pwdata[CFG_DEEP_SLEEP_ARM_BIT];
         global_int_enable <= pwdata[CFG_GIE_BIT];
         wdt_enable        <= pwdata[CFG_WDTEN_BIT];
         fail_safe_clock_monitor_enable       <= pwdata[CFG_FAIL_SAFE_CLOCK_MONITOR_BIT];
      end
   end

   // Start-up status falls when internal block is picked, rises after timer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         startup_timer_status <= 1'b0;
      end else if (clock_source_select[1]) begin
         startup_timer_status <= 1'b0;
      end else if (!delay_busy && state == RUN) begin
         startup_timer_status <= 1'b1;
      end
   end

   // Hardware sets win over software clears in the same cycle.
   wire [7:0] ds_set_low = (state != DEEP_SLEEP) ? 8'h00_00 :
                           ds_fault ? 8'h00_80 :
                           ds_ultra_low_power_wake ? 8'h00_20 :
                           ds_watchdog ? 8'h00_10 :
                           ds_calendar_alarm ? 8'h00_08 :
                           ds_master_clear_pin ? 8'h00_04 : 8'h00_00;
   wire       ds_set_ioc = (state == DEEP_SLEEP) && !ds_set_low[WL_FLT] &&
                           (ds_set_low == 8'h00_00) && ds_interrupt_on_change;
   wire [7:0] por_set    = {7'h00, power_on_detect};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_low  <= WAKE_LOW_RESET;
         wake_high <= 8'h00_00;
      end else begin
         if (wr_en && sel_wl) begin
            wake_low <= (pwdata[7:0] & WAKE_LOW_MASK) | ds_set_low | por_set;
         end else if (!ds_seen) begin
            wake_low <= wake_low | ds_set_low | por_set;
         end else begin
            wake_low <= wake_low | por_set;
         end
         if (wr_en && sel_wh) begin
            wake_high <= (pwdata[7:0] & WAKE_HIGH_MASK) |
                         {7'h00, ds_set_ioc};
         end else if (!ds_seen) begin
            wake_high <= wake_high | {7'h00, ds_set_ioc};
         end
      end
   end

   wire [7:0] osc_rd = {idle_on_sleep_select, 3'h0, startup_timer_status,
                        1'b0, clock_source_select};
   wire [7:0] cfg_rd = {global_int_enable, 4'h0, fail_safe_clock_monitor_enable, wdt_enable,
                        deep_sleep_arm};
   wire [7:0] rd_mux = sel_osc  ? osc_rd :
                       sel_wl   ? (wake_low & WAKE_LOW_MASK) :
                       sel_wh   ? (wake_high & WAKE_HIGH_MASK) :
                       sel_cfg  ? cfg_rd :
                       sel_stat ? {5'h00, state} : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h00_0000, rd_mux};
      end
   end
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Clock gating follows the mode: Sleep stops CPU and peripheral clocks; internal RC stays on only for watchdog or fail-safe monitor.
   assign active_clock_source = clock_source_select;
   assign cpu_clock_enable    = (state == RUN);
   assign periph_clock_enable = (state == RUN) || (state == IDLE);
   assign primary_osc_enable  = !clock_source_select[1] &&
                                periph_clock_enable;
   assign internal_rc_clock_enable = periph_clock_enable || wdt_enable ||
                                     fail_safe_clock_monitor_enable;
   assign core_supply_regulator_on = (state != DEEP_SLEEP);
   assign watchdog_clear = (state == RUN && (sleep_op || watchdog_clear_op)) ||
                           (fail_safe_clock_monitor_enable && clock_lost);
   assign watchdog_reset_req = (state == RUN) && watchdog_timeout;
   assign resume_pulse     = (state == WAKE_WAIT) && !delay_busy;
   assign branch_to_vector = resume_pulse && global_int_enable &&
                             int_flags_any_enabled;
   assign power_mode       = state;

   AST_IDLE_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
      state == RUN && sleep_op && idle_on_sleep_select |=> state == IDLE)
      else $error("sleep with idle bit did not enter idle");
   AST_SLEEP_NOCLK: assert property (@(posedge pclk) disable iff (!presetn)
      state == SLEEP |-> !periph_clock_enable && !cpu_clock_enable)
      else $error("clock running in sleep");
   AST_WDT_RUN_RST: assert property (@(posedge pclk) disable iff (!presetn)
      state == RUN && watchdog_timeout |-> watchdog_reset_req)
      else $error("watchdog in run gave no reset");
   AST_WDT_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
      low_power && watchdog_timeout |=> state == WAKE_WAIT)
      else $error("watchdog did not end low power");
   AST_NO_SPURIOUS: assert property (@(posedge pclk) disable iff (!presetn)
      low_power && !int_rise && !watchdog_timeout |=> $stable(state))
      else $error("low power left without a trigger");
   AST_RC_ALIVE: assert property (@(posedge pclk) disable iff (!presetn)
      wdt_enable || fail_safe_clock_monitor_enable |-> internal_rc_clock_enable)
      else $error("rc clock stopped with watchdog on");
   AST_REG_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      state == DEEP_SLEEP |-> !core_supply_regulator_on && !cpu_clock_enable)
      else $error("regulator on in deep sleep");
   AST_SCS_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
      state == WAKE_WAIT && !wr_osc |=> $stable(clock_source_select))
      else $error("wake changed clock select");
   AST_WDT_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      state == RUN && sleep_op |-> watchdog_clear)
      else $error("sleep did not clear watchdog");
   AST_ONE_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(wake_low[WL_FLT]) && !$past(wr_en) |-> !wake_low[WL_ULP])
      else $error("two wake causes set together");
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the power mode and wake cause controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   $display("Error %s expected %h seen %h", nm, e, g); n_fail++; end end
module testbench
   import pwr_mode_pkg::*;
;
   typedef struct {
      logic        wr;
      logic [13:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic        err;
   } row_t;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, er, sleep_op, watchdog_clear_op;
   logic        int_flags_any_enabled, watchdog_timeout, clock_lost;
   logic [1:0]  source_running, active_clock_source;
   logic        power_on_detect;
   logic [5:0]  ds_in;
   logic        cpu_clock_enable, periph_clock_enable, primary_osc_enable;
   logic        internal_rc_clock_enable, core_supply_regulator_on;
   logic        watchdog_clear, watchdog_reset_req, branch_to_vector;
   logic        resume_pulse;
   logic [2:0]  power_mode;
   int          n_fail, checks_done;
   row_t        rows [9];
   power_mode_wake_control #(
      .PRIMARY_OSC_CONFIG(PRIMARY_OSC_CONFIG_EC),
      .OST_LEN(8)
   ) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sleep_op(sleep_op),
      .watchdog_clear_op(watchdog_clear_op),
      .int_flags_any_enabled(int_flags_any_enabled),
      .watchdog_timeout(watchdog_timeout), .clock_lost(clock_lost),
      .source_running(source_running), .power_on_detect(power_on_detect),
      .ds_fault(ds_in[5]), .ds_ultra_low_power_wake(ds_in[4]),
      .ds_watchdog(ds_in[3]), .ds_calendar_alarm(ds_in[2]),
      .ds_master_clear_pin(ds_in[1]), .ds_interrupt_on_change(ds_in[0]),
      .active_clock_source(active_clock_source),
      .cpu_clock_enable(cpu_clock_enable),
      .periph_clock_enable(periph_clock_enable),
      .primary_osc_enable(primary_osc_enable),
      .internal_rc_clock_enable(internal_rc_clock_enable),
      .core_supply_regulator_on(core_supply_regulator_on),
      .watchdog_clear(watchdog_clear),
      .watchdog_reset_req(watchdog_reset_req),
      .branch_to_vector(branch_to_vector), .resume_pulse(resume_pulse),
      .power_mode(power_mode));
   always #25 pclk = ~pclk;
   task automatic complete_run();
      if (n_fail == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Holds the request until pready is seen high, failing after 20 cycles; no wait count assumed.
   task automatic apb(input logic w, input logic [13:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin n_fail++; complete_run(); end
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   function automatic logic [2:0] probe(input int s);
      case (s)
         0: return power_mode;
         1: return {1'b0, active_clock_source};
         default: return {2'b00, resume_pulse};
      endcase
   endfunction
   task automatic wait_for(input int s, input logic [2:0] v);
      int i;
      for (i = 0; i < 100; i++) begin
         if (probe(s) === v) return;
         @(posedge pclk); #1;
      end
      $display("Error wait %0d expected %h seen %h", s, v, probe(s));
      n_fail++;
      complete_run();
   endtask
   task automatic sleep_now();
      @(posedge pclk); sleep_op <= 1'b1; #1;
      `CHK("wdt clear on sleep", 1'b1, watchdog_clear)
      @(posedge pclk); sleep_op <= 1'b0; #1;
   endtask
   task automatic deep(input logic [5:0] t, input logic [7:0] lo,
                       input logic [7:0] hi);
      apb(1, ADDR_WAKE_LOW, 32'h0000_0000);
      apb(1, ADDR_WAKE_HIGH, 32'h0000_0000);
      apb(1, ADDR_WAKE_CFG, 32'h0000_0003);
      apb(1, ADDR_OSC_CTRL, 32'h0000_0002);
      sleep_now();
      wait_for(0, DEEP_SLEEP);
      `CHK("regulator", 1'b0, core_supply_regulator_on)
      `CHK("rc with wdt", 1'b1, internal_rc_clock_enable)
      @(posedge pclk); ds_in <= t;
      @(posedge pclk); #1;
      wait_for(0, RUN);
      ds_in <= 6'b00_0000;
      apb(0, ADDR_WAKE_LOW, 32'h0000_0000);
      `CHK("wake low", {24'h00_0000, lo}, rd)
      apb(0, ADDR_WAKE_HIGH, 32'h0000_0000);
      `CHK("wake high", {24'h00_0000, hi}, rd)
   endtask
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; sleep_op = 0; watchdog_clear_op = 0; clock_lost = 0;
      int_flags_any_enabled = 0; watchdog_timeout = 0; source_running = 0;
      power_on_detect = 0; ds_in = 0; n_fail = 0; checks_done = 0;
      rows[0] = '{0, ADDR_WAKE_LOW, 0, 32'h0000_0001, 0};
      rows[1] = '{0, ADDR_WAKE_HIGH, 0, 0, 0};
      rows[2] = '{0, ADDR_OSC_CTRL, 0, 32'h0000_0002, 0};
      rows[3] = '{1, ADDR_OSC_CTRL, 32'h0000_0080, 32'h0000_0082, 0};
      rows[4] = '{1, ADDR_WAKE_CFG, 32'h0000_0086, 32'h0000_0086, 0};
      rows[5] = '{1, ADDR_WAKE_HIGH, 32'h0000_00fe, 0, 0};
      rows[6] = '{0, ADDR_STATUS, 0, 0, 0};
      rows[7] = '{1, 14'h0f60, 32'h0000_00ff, 0, 1};
      rows[8] = '{1, ADDR_WAKE_LOW, 0, 0, 0};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[k]) begin
         if (rows[k].wr) apb(1, rows[k].a, rows[k].d);
         apb(0, rows[k].a, 32'h0000_0000);
         `CHK("row read", rows[k].e, rd)
         `CHK("row error", rows[k].err, er)
      end
      // Internal-clock idle, interrupt wake with vectoring enabled.
      apb(1, ADDR_WAKE_CFG, 32'h0000_0080);
      sleep_now();
      wait_for(0, IDLE);
      `CHK("idle cpu clk", 1'b0, cpu_clock_enable)
      `CHK("idle periph clk", 1'b1, periph_clock_enable)
      int_flags_any_enabled <= 1'b1;
      wait_for(2, 3'h1);
      `CHK("vector", 1'b1, branch_to_vector)
      int_flags_any_enabled <= 1'b0;
      wait_for(0, RUN);
      apb(0, ADDR_OSC_CTRL, 32'h0000_0000);
      `CHK("osc after wake", 32'h0000_0082, rd)
      // Sleep ignores non-wake inputs, then leaves on a watchdog time-out.
      apb(1, ADDR_WAKE_CFG, 32'h0000_0000);
      apb(1, ADDR_OSC_CTRL, 32'h0000_0002);
      sleep_now();
      wait_for(0, SLEEP);
      `CHK("sleep clocks", 2'b00,
           {cpu_clock_enable, periph_clock_enable})
      @(posedge pclk); clock_lost <= 1'b1; watchdog_clear_op <= 1'b1;
      repeat (4) @(posedge pclk);
      clock_lost <= 1'b0; watchdog_clear_op <= 1'b0; #1;
      `CHK("still asleep", SLEEP, power_mode)
      @(posedge pclk); watchdog_timeout <= 1'b1; #1;
      `CHK("no wdt reset asleep", 1'b0, watchdog_reset_req)
      @(posedge pclk); watchdog_timeout <= 1'b0; #1;
      wait_for(2, 3'h1);
      `CHK("no vector", 1'b0, branch_to_vector)
      wait_for(0, RUN);
      @(posedge pclk); watchdog_timeout <= 1'b1; #1;
      `CHK("wdt reset in run", 1'b1, watchdog_reset_req)
      @(posedge pclk); watchdog_timeout <= 1'b0; watchdog_clear_op <= 1'b1;
      #1;
      `CHK("wdt clear op", 1'b1, watchdog_clear)
      apb(1, ADDR_WAKE_CFG, 32'h0000_0004);
      watchdog_clear_op <= 1'b0; clock_lost <= 1'b1; #1;
      `CHK("clock lost clear", 1'b1, watchdog_clear)
      @(posedge pclk); clock_lost <= 1'b0;
      // Clock switching to a running primary and back to internal.
      source_running <= 2'b01;
      apb(1, ADDR_OSC_CTRL, 32'h0000_0000);
      wait_for(1, SCS_PRIMARY);
      `CHK("primary osc on", 1'b1, primary_osc_enable)
      repeat (6) @(posedge pclk);
      apb(0, ADDR_OSC_CTRL, 32'h0000_0000);
      `CHK("start-up set", 32'h0000_0008, rd)
      apb(1, ADDR_OSC_CTRL, 32'h0000_0002);
      wait_for(1, SCS_INTERNAL);
      `CHK("primary osc off", 1'b0, primary_osc_enable)
      apb(0, ADDR_OSC_CTRL, 32'h0000_0000);
      `CHK("start-up status", 32'h0000_0002, rd)
      // Every deep sleep wake cause, with two simultaneous pairs.
      deep(6'b00_1100, 8'h10, 8'h00);
      deep(6'b10_0010, 8'h80, 8'h00);
      deep(6'b01_0000, 8'h20, 8'h00);
      deep(6'b00_0100, 8'h08, 8'h00);
      deep(6'b00_0010, 8'h04, 8'h00);
      deep(6'b00_0001, 8'h00, 8'h01);
      @(posedge pclk); power_on_detect <= 1'b1;
      @(posedge pclk); power_on_detect <= 1'b0;
      apb(0, ADDR_WAKE_LOW, 32'h0000_0000);
      `CHK("power-on flag", 32'h0000_0001, rd)
      // Primary idle wake with an external clock skips the start-up wait.
      apb(1, ADDR_WAKE_CFG, 32'h0000_0000);
      apb(1, ADDR_OSC_CTRL, 32'h0000_0080);
      wait_for(1, SCS_PRIMARY);
      sleep_now();
      wait_for(0, IDLE);
      repeat (5) @(posedge pclk);
      int_flags_any_enabled <= 1'b1;
      @(posedge pclk); #1;
      `CHK("no start-up wait", 1'b1, resume_pulse)
      int_flags_any_enabled <= 1'b0;
      wait_for(0, RUN);
      // Reset while asleep on the primary source.
      apb(1, ADDR_OSC_CTRL, 32'h0000_0000);
      wait_for(1, SCS_PRIMARY);
      sleep_now();
      wait_for(0, SLEEP);
      @(posedge pclk); presetn <= 1'b0;
      @(posedge pclk); #1;
      `CHK("reset source", SCS_INTERNAL, active_clock_source)
      `CHK("reset mode", RUN, power_mode)
      @(posedge pclk); presetn <= 1'b1;
      complete_run();
   end
endmodule
`default_nettype wire
